// ===== verilog/pcmsp_pkg.sv
// Constants shared by the serial PCM port of the telephone codec.
// Assumes a 100 MHz system clock; bit clocks come from the highway controller.
package pcmsp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned FILTER_HZ = 256000;
  localparam int unsigned DECODE_DELAY_NS = 10000;
  localparam int unsigned DECODE_CYCLES = DECODE_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned POWERDOWN_NS = 1000000;
  localparam int unsigned POWERDOWN_CYCLES = POWERDOWN_NS / CLK_PERIOD_NS;
  localparam int unsigned RX_STATIC_NS = 20000;
  localparam int unsigned RX_STATIC_CYCLES = RX_STATIC_NS / CLK_PERIOD_NS;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [3:0] BEFORE_LAST_BIT = 4'h7;
  localparam logic [1:0] LONG_SYNC_BITS = 2'h3;
  localparam logic [1:0] DRIVE_FROM_PULSE = 2'h2;
  localparam logic [7:0] EVEN_BIT_MASK = 8'h55;
  localparam logic MODE_RESET_LONG = 1'b0;
  localparam logic POWERED_DOWN_RESET = 1'b1;
  localparam logic RX_STATIC_RESET = 1'b0;
endpackage

// ===== verilog/pcmsp_serial_port.sv
// Serial PCM time-slot port: frame mode detect, 8-bit transmit slot, 8-bit receive slot,
// A-law encode/decode, auto power-down. Assumes syncs are synchronous to their bit clocks.
// Notes on behaviour
// RULE1 - After reset, short frame mode is assumed
// RULE2 - Controller makes short syncs one bit wide
// RULE3 - Short transmit: sign on next rise, eight bits
// RULE4 - Short receive: latch eight bits from next fall
// RULE5 - Controller holds long syncs three bits or more
// RULE6 - Frame mode judged from transmit sync only
// RULE7 - Controller keeps sync low 160 ns at 64 kHz
// RULE8 - Long transmit: enable when sync and clock high
// RULE9 - Long transmit: disable at later of end, sync low
// RULE10 - Long receive: latch eight falls from sync rise
// RULE11 - Both modes work synchronous and asynchronous
// RULE12 - Each sync encodes; code sent next frame
// RULE13 - Codes are A-law with even bit inversion
// RULE14 - Decoder output updates 10 us after slot
// RULE15 - 256 kHz filter tick from master clock
// RULE16 - Output stays off until second transmit sync
// RULE17 - Power down 1 ms after syncs stop
// RULE18 - Static receive clock selects transmit clock
// RULE19 - One-bit sync is short, three-bit is long
// RULE20 - Each direction counts exactly eight bits
`timescale 1ns/1ps

module pcmsp_tx_fall (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync,
  input wire logic rise_active,
  input wire logic [3:0] rise_cnt,
  output logic fresh,
  output logic long_mode,
  output logic ended
);
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic sync_q;
    logic [1:0] run;
    logic long_mode;
    logic ended;
  } pcmsp_fall_s;
  pcmsp_fall_s st;
  pcmsp_fall_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.rst_s1 = rst;
    next_st.rst_s2 = st.rst_s1;
    next_st.sync_q = sync;
    if (!sync)
      next_st.run = 2'h0;
    else if (st.run != pcmsp_pkg::LONG_SYNC_BITS)
      next_st.run = st.run + 2'h1;
    // Relies on the controller's pulse widths being one or at least three bits RULE2 RULE5
    if (next_st.run == pcmsp_pkg::LONG_SYNC_BITS)
      next_st.long_mode = 1'b1; // RULE19 RULE6
    else if (!sync && st.run == 2'h1)
      next_st.long_mode = 1'b0; // RULE19 RULE6
    next_st.ended = rise_active && rise_cnt == pcmsp_pkg::LAST_BIT; // RULE3 RULE9
    if (st.rst_s2)
    begin
      next_st.sync_q = 1'b0;
      next_st.run = 2'h0;
      next_st.long_mode = pcmsp_pkg::MODE_RESET_LONG; // RULE1
      next_st.ended = 1'b0;
    end
  end

  always_ff @(posedge clk)
    st <= next_st;

  assign fresh = st.sync_q && st.run == 2'h1;
  assign long_mode = st.long_mode;
  assign ended = st.ended;

  short_default_a: assert property (@(posedge clk) st.rst_s2 |=> !st.long_mode) // RULE1
    else $error("frame mode not short after reset");
  long_detect_a: assert property (@(posedge clk) disable iff (st.rst_s2) // RULE19
    st.sync_q [*3] |-> st.long_mode) else $error("long sync not detected");
  short_detect_a: assert property (@(posedge clk) disable iff (st.rst_s2) // RULE6
    $fell(st.sync_q) && $past(st.run) == 2'h1 |-> !st.long_mode) else $error("short sync not detected");
endmodule

module pcmsp_tx_rise (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync,
  input wire logic pd,
  input wire logic fresh,
  input wire logic long_mode,
  input wire logic ended,
  input wire logic [7:0] code,
  output logic active,
  output logic [3:0] cnt,
  output logic dx,
  output logic drive,
  output logic start_tog
);
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic pd_s1;
    logic pd_s2;
    logic served;
    logic [1:0] starts;
    logic active;
    logic drive;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic start_tog;
  } pcmsp_rise_s;
  pcmsp_rise_s st;
  pcmsp_rise_s next_st;

  always_comb
  begin
    logic start;
    logic [1:0] base;
    start = long_mode ? (sync && !st.served) : fresh; // RULE8 RULE3
    base = st.pd_s2 ? 2'h0 : st.starts;
    next_st = st;
    next_st.rst_s1 = rst;
    next_st.rst_s2 = st.rst_s1;
    next_st.pd_s1 = pd;
    next_st.pd_s2 = st.pd_s1;
    next_st.served = sync && (st.served || start);
    if (start)
    begin
      next_st.active = 1'b1;
      next_st.cnt = 4'h1;
      next_st.shreg = code; // RULE12
      next_st.start_tog = !st.start_tog; // RULE12
      next_st.starts = (base == pcmsp_pkg::DRIVE_FROM_PULSE) ? base : base + 2'h1;
      next_st.drive = next_st.starts == pcmsp_pkg::DRIVE_FROM_PULSE; // RULE16
    end
    else
    begin
      // Power-down clears the count only at a start; pd lingers a few rises after the powering-up pulse
      next_st.starts = st.starts;
      if (st.pd_s2)
        next_st.drive = 1'b0; // RULE16
      if (st.active && st.cnt < pcmsp_pkg::LAST_BIT)
      begin
        next_st.cnt = st.cnt + 4'h1; // RULE20 RULE3 RULE8
        next_st.shreg = {st.shreg[6:0], 1'b0};
      end
      else if (ended && !(long_mode && sync))
        next_st.active = 1'b0; // RULE9
    end
    if (st.rst_s2)
    begin
      next_st.served = 1'b0;
      next_st.starts = 2'h0;
      next_st.active = 1'b0;
      next_st.drive = 1'b0;
      next_st.cnt = 4'h0;
      next_st.shreg = 8'h00;
      next_st.start_tog = 1'b0;
    end
  end

  always_ff @(posedge clk)
    st <= next_st;

  assign active = st.active;
  assign cnt = st.cnt;
  assign dx = st.shreg[7];
  assign drive = st.drive;
  assign start_tog = st.start_tog;

  slot_length_a: assert property (@(posedge clk) disable iff (st.rst_s2) // RULE20
    $rose(st.active) |-> (st.active && st.cnt < pcmsp_pkg::LAST_BIT) [*7] ##1 (st.cnt == pcmsp_pkg::LAST_BIT))
    else $error("transmit slot is not eight bits");
  sign_first_a: assert property (@(posedge clk) disable iff (st.rst_s2) // RULE3
    $rose(st.active) |-> st.shreg[7] == $past(code[7])) else $error("sign bit not sent first");
  early_drive_a: assert property (@(posedge clk) disable iff (st.rst_s2) // RULE16
    st.pd_s2 |=> !st.drive) else $error("output driven before second sync");
endmodule

module pcmsp_rx_slot (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync,
  input wire logic data,
  input wire logic long_in,
  output logic [7:0] byte_out,
  output logic done_tog,
  output logic alive
);
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic long_s1;
    logic long_s2;
    logic sync_prev;
    logic busy;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] byte_out;
    logic done_tog;
    logic alive;
  } pcmsp_rx_s;
  pcmsp_rx_s st;
  pcmsp_rx_s next_st;

  always_comb
  begin
    logic rise;
    rise = sync && !st.sync_prev;
    next_st = st;
    next_st.rst_s1 = rst;
    next_st.rst_s2 = st.rst_s1;
    next_st.long_s1 = long_in;
    next_st.long_s2 = st.long_s1;
    next_st.sync_prev = sync;
    next_st.alive = !st.alive;
    if (st.busy)
    begin
      next_st.shreg = {st.shreg[6:0], data}; // RULE4 RULE10
      next_st.cnt = st.cnt + 4'h1;
      if (next_st.cnt == pcmsp_pkg::LAST_BIT)
      begin
        next_st.busy = 1'b0; // RULE20
        next_st.byte_out = next_st.shreg;
        next_st.done_tog = !st.done_tog;
      end
    end
    // Short sync may land on the last data fall; long sync may not
    if (rise && (!st.busy || (st.cnt == pcmsp_pkg::BEFORE_LAST_BIT && !st.long_s2)))
    begin
      next_st.busy = 1'b1;
      if (st.long_s2)
      begin
        next_st.cnt = 4'h1; // RULE10
        next_st.shreg = {st.shreg[6:0], data};
      end
      else
        next_st.cnt = 4'h0; // RULE4
    end
    if (st.rst_s2)
    begin
      next_st.sync_prev = 1'b0;
      next_st.busy = 1'b0;
      next_st.cnt = 4'h0;
      next_st.shreg = 8'h00;
      next_st.byte_out = 8'h00;
      next_st.done_tog = 1'b0;
      next_st.alive = 1'b0;
    end
  end

  always_ff @(posedge clk)
    st <= next_st;

  assign byte_out = st.byte_out;
  assign done_tog = st.done_tog;
  assign alive = st.alive;

  rx_eight_a: assert property (@(posedge clk) disable iff (st.rst_s2) // RULE4
    $changed(st.done_tog) |-> $past(st.busy) && $past(st.cnt) == pcmsp_pkg::BEFORE_LAST_BIT)
    else $error("receive slot is not eight bits");
  rx_long_start_a: assert property (@(posedge clk) disable iff (st.rst_s2) // RULE10
    st.long_s2 && sync && !st.sync_prev && !st.busy |=> st.busy && st.cnt == 4'h1)
    else $error("long receive did not latch on first fall");
endmodule

module pcmsp_serial_port #(
  parameter int unsigned POWERDOWN_CYCLES_P = pcmsp_pkg::POWERDOWN_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic TX_BIT_CLOCK,
  input wire logic RX_BIT_CLOCK_OR_RATE_SELECT,
  input wire logic TX_FRAME_SYNC,
  input wire logic RX_FRAME_SYNC,
  input wire logic RX_DATA,
  input wire logic [12:0] TX_LINEAR,
  output logic DX_OUT,
  output logic DX_OE,
  output logic TX_SLOT_INDICATOR_N_OUT,
  output logic TX_SLOT_INDICATOR_N_OE,
  output logic [12:0] RX_LINEAR,
  output logic RX_LINEAR_VALID,
  output logic LONG_FRAME,
  output logic POWERED_DOWN,
  output logic FILTER_TICK
);
  typedef struct packed {
    logic ts1, ts2, ts3;
    logic ra1, ra2, ra3;
    logic rb1, rb2, rb3;
    logic al1, al2, al3;
    logic ls1, ls2;
    logic [15:0] static_cnt;
    logic rx_static;
    logic [31:0] idle_cnt;
    logic pd;
    logic [7:0] code;
    logic [7:0] dec_byte;
    logic dec_busy;
    logic [15:0] dec_cnt;
    logic [12:0] rx_linear;
    logic rx_valid;
    logic [31:0] acc;
    logic tick;
  } pcmsp_top_s;
  pcmsp_top_s st;
  pcmsp_top_s next_st;

  logic tx_fall_clk;
  logic rx_fall_clk;
  logic fresh, long_mode, ended, active, dx, drive, start_tog;
  logic [3:0] cnt;
  logic [7:0] rx_a_byte, rx_b_byte;
  logic rx_a_tog, rx_b_tog, rx_a_alive;
  logic tx_ev, rx_ev;

  function automatic logic [7:0] alaw_encode(input logic [12:0] lin);
    logic [11:0] mag;
    logic [2:0] seg;
    logic [3:0] mant;
    mag = lin[12] ? ~lin[11:0] : lin[11:0];
    seg = 3'h0;
    mant = mag[4:1];
    for (int i = 5; i < 12; i++)
    begin
      if (mag[i])
      begin
        seg = 3'(i - 4);
        mant = mag[i - 1 -: 4];
      end
    end
    return {~lin[12], seg, mant} ^ pcmsp_pkg::EVEN_BIT_MASK;
  endfunction

  function automatic logic [12:0] alaw_decode(input logic [7:0] code);
    logic [7:0] c;
    logic [11:0] mag;
    c = code ^ pcmsp_pkg::EVEN_BIT_MASK;
    if (c[6:4] == 3'h0)
      mag = {7'h00, c[3:0], 1'b1};
    else
      mag = {6'h00, 1'b1, c[3:0], 1'b1} << (c[6:4] - 3'h1);
    return c[7] ? {1'b0, mag} : ~{1'b0, mag};
  endfunction

  // Same-source edges: fall and rise halves of the transmit link form one domain
  assign tx_fall_clk = ~TX_BIT_CLOCK;
  assign rx_fall_clk = ~RX_BIT_CLOCK_OR_RATE_SELECT;

  pcmsp_tx_fall u_fall (
    .clk(tx_fall_clk),
    .rst(RST),
    .sync(TX_FRAME_SYNC),
    .rise_active(active),
    .rise_cnt(cnt),
    .fresh(fresh),
    .long_mode(long_mode),
    .ended(ended)
  );

  pcmsp_tx_rise u_rise (
    .clk(TX_BIT_CLOCK),
    .rst(RST),
    .sync(TX_FRAME_SYNC),
    .pd(st.pd),
    .fresh(fresh),
    .long_mode(long_mode),
    .ended(ended),
    .code(st.code),
    .active(active),
    .cnt(cnt),
    .dx(dx),
    .drive(drive),
    .start_tog(start_tog)
  );

  // Receiver on its own clock and a twin on the transmit clock; the twin serves when
  // the receive clock stands still, so both clocking setups keep both frame formats RULE11
  pcmsp_rx_slot u_rx_own (
    .clk(rx_fall_clk),
    .rst(RST),
    .sync(RX_FRAME_SYNC),
    .data(RX_DATA),
    .long_in(long_mode),
    .byte_out(rx_a_byte),
    .done_tog(rx_a_tog),
    .alive(rx_a_alive)
  );

  pcmsp_rx_slot u_rx_shared (
    .clk(tx_fall_clk),
    .rst(RST),
    .sync(RX_FRAME_SYNC),
    .data(RX_DATA),
    .long_in(long_mode),
    .byte_out(rx_b_byte),
    .done_tog(rx_b_tog),
    .alive()
  );

  assign tx_ev = st.ts2 != st.ts3;
  assign rx_ev = st.rx_static ? (st.rb2 != st.rb3) : (st.ra2 != st.ra3); // RULE18

  always_comb
  begin
    next_st = st;
    {next_st.ts1, next_st.ts2, next_st.ts3} = {start_tog, st.ts1, st.ts2};
    {next_st.ra1, next_st.ra2, next_st.ra3} = {rx_a_tog, st.ra1, st.ra2};
    {next_st.rb1, next_st.rb2, next_st.rb3} = {rx_b_tog, st.rb1, st.rb2};
    {next_st.al1, next_st.al2, next_st.al3} = {rx_a_alive, st.al1, st.al2};
    {next_st.ls1, next_st.ls2} = {long_mode, st.ls1};
    if (st.al2 != st.al3)
    begin
      next_st.static_cnt = 16'h0000;
      next_st.rx_static = 1'b0;
    end
    else if (st.static_cnt == 16'(pcmsp_pkg::RX_STATIC_CYCLES - 1))
      next_st.rx_static = 1'b1; // RULE18
    else
      next_st.static_cnt = st.static_cnt + 16'h0001;
    if (tx_ev || rx_ev)
    begin
      next_st.idle_cnt = 32'h0000_0000;
      next_st.pd = 1'b0; // RULE17
    end
    else if (!st.pd && st.idle_cnt == 32'(POWERDOWN_CYCLES_P - 1))
      next_st.pd = 1'b1; // RULE17
    else if (!st.pd)
      next_st.idle_cnt = st.idle_cnt + 32'h0000_0001;
    // Code stays stable for a whole frame, so the transmit side reads it without a handshake
    if (tx_ev)
      next_st.code = alaw_encode(TX_LINEAR); // RULE12 RULE13
    next_st.rx_valid = 1'b0;
    if (rx_ev)
    begin
      next_st.dec_byte = st.rx_static ? rx_b_byte : rx_a_byte;
      next_st.dec_busy = 1'b1; // RULE14
      next_st.dec_cnt = 16'h0000;
    end
    else if (st.dec_busy && st.dec_cnt == 16'(pcmsp_pkg::DECODE_CYCLES - 1))
    begin
      next_st.dec_busy = 1'b0;
      next_st.rx_linear = alaw_decode(st.dec_byte); // RULE14
      next_st.rx_valid = 1'b1;
    end
    else if (st.dec_busy)
      next_st.dec_cnt = st.dec_cnt + 16'h0001;
    // Fractional divider: average rate exact, single ticks jitter by one cycle
    next_st.tick = 1'b0;
    if (st.acc + pcmsp_pkg::FILTER_HZ >= pcmsp_pkg::CLK_HZ)
    begin
      next_st.acc = st.acc + pcmsp_pkg::FILTER_HZ - pcmsp_pkg::CLK_HZ;
      next_st.tick = !st.pd; // RULE15
    end
    else
      next_st.acc = st.acc + pcmsp_pkg::FILTER_HZ;
    if (RST)
    begin
      next_st = '0;
      next_st.pd = pcmsp_pkg::POWERED_DOWN_RESET;
      next_st.rx_static = pcmsp_pkg::RX_STATIC_RESET;
    end
  end

  always_ff @(posedge CLK)
    st <= next_st;

  assign DX_OUT = dx;
  assign DX_OE = active && drive && (!ended || (long_mode && TX_FRAME_SYNC)); // RULE8 RULE9 RULE3
  assign TX_SLOT_INDICATOR_N_OUT = 1'b0;
  assign TX_SLOT_INDICATOR_N_OE = DX_OE;
  assign RX_LINEAR = st.rx_linear;
  assign RX_LINEAR_VALID = st.rx_valid;
  assign LONG_FRAME = st.ls2;
  assign POWERED_DOWN = st.pd;
  assign FILTER_TICK = st.tick;

  power_up_a: assert property (@(posedge CLK) disable iff (RST) // RULE17
    tx_ev |=> !st.pd) else $error("sync did not power up");
  decode_delay_a: assert property (@(posedge CLK) disable iff (RST) // RULE14
    st.rx_valid |-> $past(st.dec_cnt) == 16'(pcmsp_pkg::DECODE_CYCLES - 1)) else $error("decode delay wrong");
  decode_wait_a: assert property (@(posedge CLK) disable iff (RST) // RULE14
    $rose(st.dec_busy) |-> !st.rx_valid [*8]) else $error("decoder output too early");
  rx_select_a: assert property (@(posedge CLK) disable iff (RST) // RULE18
    st.rx_static && st.rb2 != st.rb3 |=> st.dec_busy && st.dec_cnt == 16'h0000) else $error("shared clock ignored");
endmodule

// ===== test/pcmsp_highway.sv
// Highway controller model: free-running bit clock, both frame syncs, receive data, transmit capture.
// Assumes synchronous clocking: one bit clock serves both directions of the port.
`timescale 1ns/1ps
module pcmsp_highway (
  output logic BCLK,
  output logic TX_SYNC,
  output logic RX_SYNC,
  output logic RX_DATA,
  input wire logic DX_OUT,
  input wire logic DX_OE,
  input wire logic SLOT_N_OUT,
  input wire logic SLOT_N_OE
);
  realtime t_end;

  initial
  begin
    BCLK = 1'b0;
    TX_SYNC = 1'b0;
    RX_SYNC = 1'b0;
    RX_DATA = 1'b0;
    t_end = 0;
    #3.3;
    forever #6 BCLK = ~BCLK;
  end

  // One frame; outputs change just after rising edges, the slot is sampled 3 ns after each rise
  task automatic frame(input int sync_bits, input bit long_m, input logic [7:0] rx_byte,
                       output logic [7:0] got, output logic [15:0] oe, output logic [15:0] low);
    int n;
    int idx;
    n = (sync_bits > 9 ? sync_bits : 9) + 3;
    got = 8'h00;
    oe = 16'h0000;
    low = 16'h0000;
    for (int k = 0; k < n; k++)
    begin
      @(posedge BCLK);
      TX_SYNC <= (k < sync_bits);
      RX_SYNC <= (k < sync_bits);
      idx = long_m ? k : k - 1;
      // Released data line shows the inverse of its last bit so stale data never matches
      RX_DATA <= (idx >= 0 && idx < 8) ? rx_byte[7 - idx] : ~RX_DATA;
      // Sample clear of both bit clock edges, never in the step that launches the output
      #3;
      oe[k] = DX_OE;
      // Open-drain indicator: the line is low only while enabled and driving zero
      low[k] = SLOT_N_OE === 1'b1 && SLOT_N_OUT === 1'b0;
      if (k >= 1 && k <= 8 && DX_OE === 1'b1)
        got[8 - k] = DX_OUT;
      @(negedge BCLK);
      if (idx == 7)
        t_end = $realtime;
    end
  endtask
endmodule

// ===== test/pcmsp_serial_port_test.sv
// Self-checking bench of the serial PCM port against an integer model of slots and A-law codes.
// Assumes the highway model drives the bit clock; the powerdown count is shortened to 2000 cycles.
`timescale 1ns/1ps
module pcmsp_serial_port_test;
  logic CLK;
  logic RST;
  logic bclk, tx_sync, rx_sync, rx_data, dx_out, dx_oe, rx_valid, long_frame, powered_down, filter_tick;
  logic [12:0] tx_linear;
  logic [12:0] rx_linear;
  logic [31:0] seed = 32'h4826967C;
  logic [7:0] exp_q[$];
  logic [7:0] got;
  logic [15:0] oe;
  logic [15:0] low;
  logic ts_out, ts_oe;
  logic rx_hold = 1'b0;
  logic [12:0] edge_inputs [4] = '{13'h0FFF, 13'h1000, 13'h0000, 13'h1FFF};
  int n_errors = 0;
  int num_checks = 0;
  int ticks = 0;

  pcmsp_serial_port #(.POWERDOWN_CYCLES_P(2000)) dut (
    .CLK(CLK), .RST(RST), .TX_BIT_CLOCK(bclk), .RX_BIT_CLOCK_OR_RATE_SELECT(bclk && !rx_hold),
    .TX_FRAME_SYNC(tx_sync), .RX_FRAME_SYNC(rx_sync), .RX_DATA(rx_data), .TX_LINEAR(tx_linear),
    .DX_OUT(dx_out), .DX_OE(dx_oe), .TX_SLOT_INDICATOR_N_OUT(ts_out), .TX_SLOT_INDICATOR_N_OE(ts_oe),
    .RX_LINEAR(rx_linear), .RX_LINEAR_VALID(rx_valid), .LONG_FRAME(long_frame),
    .POWERED_DOWN(powered_down), .FILTER_TICK(filter_tick));

  pcmsp_highway hw (.BCLK(bclk), .TX_SYNC(tx_sync), .RX_SYNC(rx_sync), .RX_DATA(rx_data),
    .DX_OUT(dx_out), .DX_OE(dx_oe), .SLOT_N_OUT(ts_out), .SLOT_N_OE(ts_oe));

  initial
    CLK = 1'b0;
  always #5 CLK = ~CLK;

  always @(negedge CLK)
    if (filter_tick === 1'b1)
      ticks++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Truncating A-law encode; negatives use the one's complement magnitude
  function automatic logic [7:0] enc(input logic [12:0] x);
    logic [11:0] m;
    logic [2:0] s;
    m = x[12] ? ~x[11:0] : x[11:0];
    s = 3'h0;
    for (int b = 5; b <= 11; b++)
      if (m[b])
        s = 3'(b - 4);
    return {~x[12], s, (s == 3'h0) ? m[4:1] : 4'(m >> s)} ^ 8'h55;
  endfunction

  function automatic logic [12:0] dec(input logic [7:0] c);
    logic [7:0] r;
    logic [11:0] m;
    r = c ^ 8'h55;
    m = (r[6:4] == 3'h0) ? {7'h00, r[3:0], 1'b1} : 12'((12'({r[3:0], 1'b1}) + 12'h020) << (r[6:4] - 3'h1));
    return r[7] ? {1'b0, m} : ~{1'b0, m};
  endfunction

  task automatic check(input logic [12:0] act, input logic [12:0] exp);
    num_checks++;
    if (act !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic complete_run();
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One frame on both directions; chk also waits for and checks the decoded sample
  task automatic run(input int sb, input bit lm, input bit chk, input bit drv, input logic [12:0] lin);
    logic [7:0] rb;
    logic [7:0] ex;
    logic [12:0] em;
    int dt;
    int t0;
    rb = 8'(rnd());
    @(negedge CLK);
    tx_linear = lin;
    exp_q.push_back(enc(lin));
    hw.frame(sb, lm, rb, got, oe, low);
    ex = 8'h00;
    if (exp_q.size() > 1)
      ex = exp_q.pop_front();
    em = drv ? (sb > 9 ? 13'h03FE : 13'h01FE) : 13'h0000;
    check({2'h0, oe[10:0]}, em);
    check({2'h0, low[10:0]}, em);
    if (drv)
      check({5'h00, got}, {5'h00, ex});
    if (chk)
    begin
      t0 = ticks;
      for (int w = 0; w < 1200 && rx_valid !== 1'b1; w++)
        @(posedge CLK) #1;
      dt = int'($realtime - hw.t_end);
      check({12'h000, rx_valid}, 13'h0001);
      check(rx_linear, dec(rb));
      check({12'h000, dt >= 10000 && dt <= 10100}, 13'h0001);
      check({12'h000, ticks - t0 >= 2 && ticks - t0 <= 3}, 13'h0001);
    end
  endtask

  initial
  begin
    #400us;
    n_errors++;
    complete_run();
  end

  initial
  begin
    RST = 1'b1;
    tx_linear = 13'h0000;
    // Link domains take reset through their own flops, so hold it longer than three cycles
    repeat (10) @(negedge CLK);
    RST = 1'b0;
    @(negedge CLK);
    check({10'h000, dx_oe, powered_down, long_frame}, 13'h0002);
    repeat (5) @(posedge bclk);
    run(1, 0, 1, 0, 13'h0FFF);
    check({12'h000, powered_down}, 13'h0000);
    for (int i = 0; i < 4; i++)
      run(1, 0, 1, 1, edge_inputs[i]);
    repeat (4) run(1, 0, 1, 1, {1'b0, 12'(rnd())});
    run(3, 1, 0, 1, {1'b0, 12'(rnd())});
    check({12'h000, long_frame}, 13'h0001);
    for (int i = 0; i < 4; i++)
      run(i[0] ? 3 : 10, 1, 1, 1, {1'b0, 12'(rnd())});
    run(1, 0, 0, 1, {1'b0, 12'(rnd())});
    check({12'h000, long_frame}, 13'h0000);
    run(1, 0, 1, 1, {1'b0, 12'(rnd())});
    // Receive clock stops here, so the rest of the run decodes on the transmit clock
    rx_hold = 1'b1;
    repeat (2100) @(negedge CLK);
    check({12'h000, powered_down}, 13'h0001);
    run(1, 0, 0, 0, {1'b0, 12'(rnd())});
    check({12'h000, powered_down}, 13'h0000);
    run(1, 0, 1, 1, {1'b0, 12'(rnd())});
    complete_run();
  end
endmodule
